// ### core/sdsc_detector.sv
/*
 * Receive symbol detector control: slicer, peak path delay, scaling,
 * scrambler with auto-sync, output muxes, gain-loop error source.
 * Assumes symbols arrive one per advance from the equalizer path and
 * that peak criteria are judged outside on the delayed peak sample.
 */
// Behaviour
// - Flag low SNR when meter exceeds limit
// - Four-level slicing at zero and twice level
// - Scale detected symbol by level for errors
// - Self-adapt error is gain output magnitude minus target
// - Bit 2 picks equalizer error for gain
// - Enabled peak hit replaces slicer output
// - Two-bit field selects channel unit output
// - Bit 4 selects feedback source
// - Two-level: sign only, slicer and scrambler magnitude forced zero
// - Four-level: scrambler handles both bits
// - Auto-sync: 23 descramble, 128 counting
// - Count above limit sets flag, stays locked
// - Miss clears count, repeats descramble phase
// - Flag unclearable while auto-sync enabled
// - Remote bit picks taps 23/5 or 23/18
// - Bit 0 selects descrambler or ones scrambler
// - Peak path delayed by 4-bit register
// - Bit 1 enables gain coefficient adaptation
// - Bit 0 makes gain step eight times
// - Seven-bit limit used only during auto-sync
module sdsc_detector (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] up_addr,
    input wire logic [7:0] up_wdata,
    input wire logic up_wr,
    input wire logic up_rd,
    output logic [7:0] up_rdata,
    input wire logic signed [15:0] snr_meter,
    input wire logic low_snr_clr,
    output logic low_snr_flag,
    input wire logic sync_clr,
    output logic sync_flag,
    input wire logic sym_valid,
    output logic sym_ready,
    input wire logic signed [15:0] dfe_sample,
    input wire logic peak_hit,
    input wire logic [1:0] peak_sym,
    output logic signed [15:0] peak_sample,
    input wire logic [1:0] tx_loop_sym,
    output logic [1:0] fb_sym,
    output logic signed [17:0] eq_error,
    output logic signed [17:0] slicer_error,
    input wire logic signed [15:0] agc_out,
    output logic signed [17:0] agc_error,
    output logic agc_adapt_en,
    output logic [3:0] agc_step_mult,
    output logic cu_valid,
    input wire logic cu_ready,
    output logic [1:0] cu_sym
);
    import sdsc_pkg::*;

    // ========================================
    // Helpers
    function automatic logic signed [17:0] sym_scale(input logic [1:0] s,
                                                     input logic signed [15:0] lv);
        logic signed [17:0] m;
        m = s[0] ? 18'(lv) : 18'(lv) * 18'sd3;
        sym_scale = s[1] ? m : -m;
    endfunction : sym_scale

    // One scrambler bit step: returns {out, next state}
    function automatic logic [LFSR_LEN:0] lfsr_step(input logic [LFSR_LEN-1:0] st,
                                                    input logic din,
                                                    input logic descr,
                                                    input logic remote);
        logic fb;
        logic o;
        fb = st[LFSR_LEN-1] ^ (remote ? st[TAP_REMOTE-1] : st[TAP_CENTRAL-1]);
        o = (descr ? din : 1'b1) ^ fb;
        lfsr_step = {o, st[LFSR_LEN-2:0], descr ? din : o};
    endfunction : lfsr_step

    // ========================================
    // Registers
    logic [15:0] snr_limit_r;
    logic [15:0] level_r;
    logic [15:0] target_r;
    logic [7:0] det_cfg_r;
    logic [PK_DLY_W-1:0] pk_dly_r;
    logic [2:0] gain_cfg_r;
    logic [ALIGN_W-1:0] align_limit_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            snr_limit_r <= {RST_BYTE, RST_BYTE};
            level_r <= {RST_BYTE, RST_BYTE};
            target_r <= {RST_BYTE, RST_BYTE};
            det_cfg_r <= RST_BYTE;
            pk_dly_r <= RST_BYTE[PK_DLY_W-1:0];
            gain_cfg_r <= RST_BYTE[2:0];
            align_limit_r <= RST_BYTE[ALIGN_W-1:0];
        end else if (up_wr) begin
            unique case (up_addr)
                ADDR_SNR_LO: snr_limit_r[7:0] <= up_wdata;
                ADDR_SNR_HI: snr_limit_r[15:8] <= up_wdata;
                ADDR_LVL_LO: level_r[7:0] <= up_wdata;
                ADDR_LVL_HI: level_r[15:8] <= up_wdata;
                ADDR_TGT_LO: target_r[7:0] <= up_wdata;
                ADDR_TGT_HI: target_r[15:8] <= up_wdata;
                ADDR_DET_CFG: det_cfg_r <= up_wdata;
                ADDR_PK_DLY: pk_dly_r <= up_wdata[PK_DLY_W-1:0];
                ADDR_GAIN_CFG: gain_cfg_r <= up_wdata[2:0];
                ADDR_ALIGN_LIMIT: align_limit_r <= up_wdata[ALIGN_W-1:0];
                default: ;
            endcase
        end
    end

    // Read data is registered; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            up_rdata <= RST_BYTE;
        end else if (up_rd) begin
            unique case (up_addr)
                ADDR_SNR_LO: up_rdata <= snr_limit_r[7:0];
                ADDR_SNR_HI: up_rdata <= snr_limit_r[15:8];
                ADDR_LVL_LO: up_rdata <= level_r[7:0];
                ADDR_LVL_HI: up_rdata <= level_r[15:8];
                ADDR_TGT_LO: up_rdata <= target_r[7:0];
                ADDR_TGT_HI: up_rdata <= target_r[15:8];
                ADDR_DET_CFG: up_rdata <= det_cfg_r;
                ADDR_PK_DLY: up_rdata <= 8'(pk_dly_r);
                ADDR_GAIN_CFG: up_rdata <= 8'(gain_cfg_r);
                ADDR_ALIGN_LIMIT: up_rdata <= 8'(align_limit_r);
                default: up_rdata <= RST_BYTE;
            endcase
        end
    end

    // ========================================
    // SNR alarm; set wins over clear
    logic snr_over;
    assign snr_over = $signed(snr_meter) > $signed(snr_limit_r);
    always_ff @(posedge clk) begin
        if (rst) begin
            low_snr_flag <= 1'b0;
        end else if (snr_over) begin
            low_snr_flag <= 1'b1;
        end else if (low_snr_clr) begin
            low_snr_flag <= 1'b0;
        end
    end

    // ========================================
    // Stream control and peak path delay line
    logic buf_in_ready;
    logic adv;
    logic signed [15:0] dly [PK_DEPTH];
    assign sym_ready = buf_in_ready;
    assign adv = sym_valid && buf_in_ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            dly[0] <= '0;
        end else if (adv) begin
            dly[0] <= dfe_sample;
        end
    end
    genvar gi;
    generate
        for (gi = 1; gi < PK_DEPTH; gi++) begin : g_dly
            always_ff @(posedge clk) begin
                if (rst) begin
                    dly[gi] <= '0;
                end else if (adv) begin
                    dly[gi] <= dly[gi-1];
                end
            end
        end
    endgenerate
    // Tap 0 is the undelayed sample, tap N is N symbols late
    assign peak_sample = (pk_dly_r == '0) ? dfe_sample : dly[pk_dly_r - 4'h1];

    // ========================================
    // Slicer and detector selection
    logic two_lvl;
    logic signed [15:0] level_use;
    logic signed [16:0] slice_th;
    logic [1:0] slc_sym;
    logic [1:0] det_sym;
    assign two_lvl = det_cfg_r[DET_TWO_LVL];
    // Out-of-range level is clamped so the slice never overflows
    assign level_use = $signed(level_r) < 0 ? '0 :
                       ($signed(level_r) > LEVEL_MAX ? LEVEL_MAX : $signed(level_r));
    assign slice_th = 17'(level_use) <<< 1;
    always_comb begin
        slc_sym[1] = dfe_sample >= 0;
        slc_sym[0] = !two_lvl && 17'(dfe_sample) < slice_th && 17'(dfe_sample) > -slice_th;
    end
    assign det_sym = (det_cfg_r[DET_PEAK_EN] && peak_hit) ? peak_sym : slc_sym;

    // ========================================
    // Scrambler with auto-sync search
    sdsc_sync_type sy_r;
    logic [7:0] phase_cnt_r;
    logic [8:0] agree_r;
    logic [LFSR_LEN-1:0] lfsr_r;
    logic lock_en;
    logic descr_eff;
    logic [LFSR_LEN:0] st_a;
    logic [LFSR_LEN:0] st_b;
    logic [1:0] scr_sym;
    logic [1:0] n_eq;
    logic [8:0] agree_nxt;
    logic sync_hit;

    assign lock_en = det_cfg_r[DET_LOCK];
    // Auto-sync overrides the select bit without touching it
    assign descr_eff = lock_en ? sy_r inside {SY_IDLE, SY_DESCR} : det_cfg_r[DET_DESCR];
    assign st_a = lfsr_step(lfsr_r, det_sym[1], descr_eff, det_cfg_r[DET_REMOTE]);
    assign st_b = lfsr_step(st_a[LFSR_LEN-1:0], det_sym[0], descr_eff,
                            det_cfg_r[DET_REMOTE]);
    assign scr_sym = two_lvl ? {st_a[LFSR_LEN], 1'b0} : {st_a[LFSR_LEN], st_b[LFSR_LEN]};
    assign n_eq = 2'(scr_sym[1] == det_sym[1]) + 2'(!two_lvl && scr_sym[0] == det_sym[0]);
    assign agree_nxt = agree_r + 9'(n_eq);
    assign sync_hit = sy_r == SY_ONES && agree_nxt > 9'(align_limit_r);

    always_ff @(posedge clk) begin
        if (rst) begin
            lfsr_r <= '0;
        end else if (adv) begin
            lfsr_r <= two_lvl ? st_a[LFSR_LEN-1:0] : st_b[LFSR_LEN-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sy_r <= SY_IDLE;
            phase_cnt_r <= '0;
            agree_r <= '0;
        end else if (!lock_en) begin
            sy_r <= SY_IDLE;
            phase_cnt_r <= '0;
            agree_r <= '0;
        end else if (adv) begin
            unique case (sy_r)
                SY_IDLE: begin
                    // First accepted symbol already counts as a descramble cycle
                    sy_r <= SY_DESCR;
                    phase_cnt_r <= 8'h01;
                end
                SY_DESCR: begin
                    phase_cnt_r <= phase_cnt_r + 8'h01;
                    if (phase_cnt_r == DESCR_CYCLES - 8'h01) begin
                        sy_r <= SY_ONES;
                        phase_cnt_r <= '0;
                    end
                end
                SY_ONES: begin
                    agree_r <= agree_nxt;
                    phase_cnt_r <= phase_cnt_r + 8'h01;
                    if (sync_hit) begin
                        sy_r <= SY_LOCKED;
                    end else if (phase_cnt_r == ONES_CYCLES - 8'h01) begin
                        sy_r <= SY_DESCR;
                        phase_cnt_r <= '0;
                        agree_r <= '0;
                    end
                end
                SY_LOCKED: ;
            endcase
        end
    end

    // Clear ignored while auto-sync is enabled
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_flag <= 1'b0;
        end else if (adv && sync_hit) begin
            sync_flag <= 1'b1;
        end else if (sync_clr && !lock_en) begin
            sync_flag <= 1'b0;
        end
    end

    // ========================================
    // Feedback, errors and gain loop
    logic [1:0] fb_nxt;
    logic [1:0] cu_nxt;
    assign fb_nxt = det_cfg_r[DET_FB_SEL] ? scr_sym : det_sym;
    always_comb begin
        unique case (det_cfg_r[DET_MUX_LO +: 2])
            MUX_LOOP: cu_nxt = tx_loop_sym;
            MUX_SCR: cu_nxt = scr_sym;
            default: cu_nxt = fb_nxt; // Reserved code follows feedback
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fb_sym <= '0;
            eq_error <= '0;
            slicer_error <= '0;
        end else if (adv) begin
            fb_sym <= fb_nxt;
            eq_error <= 18'(dfe_sample) - sym_scale(det_sym, level_use);
            slicer_error <= 18'(dfe_sample) - sym_scale(slc_sym, level_use);
        end
    end

    logic signed [16:0] agc_abs;
    assign agc_abs = agc_out < 0 ? -17'(agc_out) : 17'(agc_out);
    always_ff @(posedge clk) begin
        if (rst) begin
            agc_error <= '0;
        end else if (gain_cfg_r[GAIN_ERR_SEL]) begin
            agc_error <= 18'(dfe_sample) - sym_scale(det_sym, level_use);
        end else begin
            agc_error <= 18'(agc_abs) - 18'($signed(target_r));
        end
    end
    assign agc_adapt_en = gain_cfg_r[GAIN_ADAPT];
    assign agc_step_mult = gain_cfg_r[GAIN_STEP] ? STEP_FAST : STEP_SLOW;

    // ========================================
    // Two-entry buffer to the channel unit
    logic [1:0] buf_mem [BUF_DEPTH];
    logic buf_wp_r;
    logic buf_rp_r;
    logic [1:0] buf_cnt_r;
    logic buf_pop;
    // Full buffer stalls the symbol input so no word is lost
    assign buf_in_ready = buf_cnt_r != 2'(BUF_DEPTH);
    assign cu_valid = buf_cnt_r != '0;
    assign buf_pop = cu_valid && cu_ready;
    assign cu_sym = buf_mem[buf_rp_r];

    always_ff @(posedge clk) begin
        if (rst) begin
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else if (adv) begin
            buf_mem[buf_wp_r] <= cu_nxt;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            buf_wp_r <= 1'b0;
            buf_rp_r <= 1'b0;
            buf_cnt_r <= '0;
        end else begin
            buf_wp_r <= buf_wp_r ^ adv;
            buf_rp_r <= buf_rp_r ^ buf_pop;
            buf_cnt_r <= buf_cnt_r + 2'(adv) - 2'(buf_pop);
        end
    end

    // ========================================
    // Checks
    a_snr_flag_set: assert property (@(posedge clk) disable iff (rst)
        snr_over |=> low_snr_flag) else $error("low SNR flag missed");
    a_sync_hold: assert property (@(posedge clk) disable iff (rst)
        sync_flag && lock_en |=> sync_flag) else $error("sync flag dropped");
    a_lock_stays: assert property (@(posedge clk) disable iff (rst)
        sy_r == SY_LOCKED && lock_en |=> sy_r == SY_LOCKED) else $error("lock lost");
    a_descr_len: assert property (@(posedge clk) disable iff (rst)
        sy_r == SY_DESCR |-> phase_cnt_r < DESCR_CYCLES) else $error("descr overrun");
    a_miss_clear: assert property (@(posedge clk) disable iff (rst)
        $fell(sy_r == SY_ONES) && sy_r == SY_DESCR |-> agree_r == '0)
        else $error("count kept");
    a_two_level: assert property (@(posedge clk) disable iff (rst)
        adv && two_lvl && !det_cfg_r[DET_FB_SEL] && !peak_hit |=> fb_sym[0] == 1'b0)
        else $error("magnitude set");
    a_fb_select: assert property (@(posedge clk) disable iff (rst)
        adv && det_cfg_r[DET_FB_SEL] |=> fb_sym == $past(scr_sym)) else $error("fb src");
    a_buf_bound: assert property (@(posedge clk) disable iff (rst)
        buf_cnt_r == 2'(BUF_DEPTH) |-> !sym_ready) else $error("buffer overrun");
    a_step_fast: assert property (@(posedge clk) disable iff (rst)
        gain_cfg_r[GAIN_STEP] |-> agc_step_mult == STEP_FAST) else $error("step");

endmodule : sdsc_detector

// ### common/sdsc_pkg.sv
/*
 * Constants for the symbol detector, scrambler and gain-loop control block.
 * Assumes a byte-wide microprocessor port and one symbol-rate clock.
 */
package sdsc_pkg;
    // ========================================
    // Register map
    localparam logic [7:0] ADDR_ALIGN_LIMIT = 8'h2E;
    localparam logic [7:0] ADDR_SNR_LO = 8'h34;
    localparam logic [7:0] ADDR_SNR_HI = 8'h35;
    localparam logic [7:0] ADDR_LVL_LO = 8'h36;
    localparam logic [7:0] ADDR_LVL_HI = 8'h37;
    localparam logic [7:0] ADDR_TGT_LO = 8'h38;
    localparam logic [7:0] ADDR_TGT_HI = 8'h39;
    localparam logic [7:0] ADDR_DET_CFG = 8'h3A;
    localparam logic [7:0] ADDR_PK_DLY = 8'h3B;
    localparam logic [7:0] ADDR_GAIN_CFG = 8'h3C;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // ========================================
    // Field positions
    localparam int DET_DESCR = 0;
    localparam int DET_REMOTE = 1;
    localparam int DET_LOCK = 2;
    localparam int DET_TWO_LVL = 3;
    localparam int DET_FB_SEL = 4;
    localparam int DET_MUX_LO = 5;
    localparam int DET_PEAK_EN = 7;
    localparam int GAIN_STEP = 0;
    localparam int GAIN_ADAPT = 1;
    localparam int GAIN_ERR_SEL = 2;
    localparam int ALIGN_W = 7;
    localparam int PK_DLY_W = 4;
    localparam int PK_DEPTH = 16;
    // ========================================
    // Limits, taps and counts
    localparam logic signed [15:0] LEVEL_MAX = 16'sh2AAA;
    localparam int LFSR_LEN = 23;
    localparam int TAP_REMOTE = 5;
    localparam int TAP_CENTRAL = 18;
    localparam logic [7:0] DESCR_CYCLES = 8'h17;
    localparam logic [7:0] ONES_CYCLES = 8'h80;
    localparam logic [3:0] STEP_FAST = 4'h8;
    localparam logic [3:0] STEP_SLOW = 4'h1;
    localparam int BUF_DEPTH = 2;
    // Output mux codes
    localparam logic [1:0] MUX_FB = 2'h0;
    localparam logic [1:0] MUX_LOOP = 2'h1;
    localparam logic [1:0] MUX_SCR = 2'h2;
    // Symbol bits {sign, mag}: sign 1 positive, mag 1 inner level
    typedef enum logic [1:0] {
        SY_IDLE = 2'b00,
        SY_DESCR = 2'b01,
        SY_ONES = 2'b11,
        SY_LOCKED = 2'b10
    } sdsc_sync_type;
endpackage : sdsc_pkg

// ### tb/sdsc_cu_sink.sv
/*
 * Channel-unit receive side model: pops detector output symbols and can
 * stall. Assumes the detector's valid/ready output handshake on clk.
 */
module sdsc_cu_sink (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic cu_valid,
    output logic cu_ready,
    input wire logic [1:0] cu_sym
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] got[$];
    // ========================================
    // Ready follows stall one edge late, like a real registered receiver
    always_ff @(posedge clk) begin
        if (rst) begin
            cu_ready <= 1'b0;
        end else begin
            cu_ready <= !stall;
            if (cu_valid && cu_ready) begin
                got.push_back(cu_sym);
            end
        end
    end
endmodule : sdsc_cu_sink

// ### tb/sdsc_detector_bench.sv
/*
 * Self-checking bench for the symbol detector control block.
 * Assumes sdsc_pkg constants and the channel-unit sink model.
 */
module sdsc_detector_bench import sdsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, up_wr, up_rd, low_snr_clr, low_snr_flag, sync_clr, sync_flag;
    logic sym_valid, sym_ready, peak_hit, agc_adapt_en, cu_valid, cu_ready, stall, o, b, g, o2;
    logic [7:0] up_addr, up_wdata, up_rdata, rv;
    logic [1:0] peak_sym, tx_loop_sym, fb_sym, cu_sym;
    logic [3:0] agc_step_mult;
    logic signed [15:0] snr_meter, dfe_sample, peak_sample, agc_out;
    logic signed [17:0] eq_error, slicer_error, agc_error, mag;
    logic [22:0] ls;
    int n_errors = 0;
    int checks = 0;
    int k;
    logic [7:0] ra [10] = '{ADDR_ALIGN_LIMIT, ADDR_SNR_LO, ADDR_SNR_HI, ADDR_LVL_LO,
        ADDR_LVL_HI, ADDR_TGT_LO, ADDR_TGT_HI, ADDR_DET_CFG, ADDR_PK_DLY, ADDR_GAIN_CFG};
    logic [7:0] ma [10] = '{8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h07};
    logic signed [15:0] smp [8] = '{16'sh0300, 16'sh0100, -16'sh0100, -16'sh0300,
        16'sh0250, 16'sh01FF, -16'sh0201, 16'sh6000};
    logic [1:0] sx [8] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0, 2'h2};
    logic [17:0] em [7] = '{18'h0, 18'h0, 18'h0, 18'h0, 18'h0B0, 18'h0FF, 18'h0FF};

    sdsc_detector u_dut (.clk, .rst, .up_addr, .up_wdata, .up_wr, .up_rd, .up_rdata,
        .snr_meter, .low_snr_clr, .low_snr_flag, .sync_clr, .sync_flag, .sym_valid,
        .sym_ready, .dfe_sample, .peak_hit, .peak_sym, .peak_sample, .tx_loop_sym,
        .fb_sym, .eq_error, .slicer_error, .agc_out, .agc_error, .agc_adapt_en,
        .agc_step_mult, .cu_valid, .cu_ready, .cu_sym);
    sdsc_cu_sink u_sink (.clk, .rst, .stall, .cu_valid, .cu_ready, .cu_sym);

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ========================================
    // Access tasks
    task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish();
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        up_addr <= a;
        up_wdata <= d;
        up_wr <= 1'b1;
        @(posedge clk);
        up_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        up_addr <= a;
        up_rd <= 1'b1;
        @(posedge clk);
        up_rd <= 1'b0;
        #1;
        d = up_rdata;
    endtask : rd
    // Holds valid until sym_ready is seen, gives up after a bounded wait
    task automatic sym(input logic signed [15:0] s, input logic [1:0] t);
        int i;
        @(posedge clk);
        dfe_sample <= s;
        tx_loop_sym <= t;
        sym_valid <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            if (sym_ready === 1'b1) break;
        end
        if (i == 40) begin
            chk("sym_ready", 18'h1, 18'h0);
            tally_and_finish();
        end
        @(posedge clk);
        sym_valid <= 1'b0;
        #1;
    endtask : sym
    task automatic pulse_clr(input bit snr);
        @(posedge clk);
        if (snr) low_snr_clr <= 1'b1;
        else sync_clr <= 1'b1;
        @(posedge clk);
        low_snr_clr <= 1'b0;
        sync_clr <= 1'b0;
        #1;
    endtask : pulse_clr

    // ========================================
    // Main sequence
    initial begin
        {rst, up_wr, up_rd, low_snr_clr, sync_clr, sym_valid, peak_hit, stall} = 8'hFF;
        {up_wr, up_rd, low_snr_clr, sync_clr, sym_valid, peak_hit, stall} = 7'h00;
        {up_addr, up_wdata, peak_sym, tx_loop_sym} = 20'h0;
        {snr_meter, dfe_sample, agc_out} = 48'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(ra[i], rv);
            chk("reset_value", 18'h0, rv);
            wr(ra[i], ra[i] ^ 8'hA5);
        end
        for (int i = 0; i < 10; i++) begin
            rd(ra[i], rv);
            chk("readback", (ra[i] ^ 8'hA5) & ma[i], rv & ma[i]);
        end
        wr(8'h50, 8'hFF);
        rd(8'h50, rv);
        chk("unmapped", 18'h0, rv);
        do_reset();
        wr(ADDR_SNR_HI, 8'h10);
        snr_meter <= 16'sh1000;
        repeat (3) @(posedge clk);
        #1;
        chk("snr_equal", 18'h0, low_snr_flag);
        @(posedge clk);
        snr_meter <= 16'sh1001;
        repeat (3) @(posedge clk);
        #1;
        chk("snr_above", 18'h1, low_snr_flag);
        @(posedge clk);
        snr_meter <= -16'sh0001;
        pulse_clr(1'b1);
        repeat (3) @(posedge clk);
        #1;
        chk("snr_negative", 18'h0, low_snr_flag);
        wr(ADDR_TGT_LO, 8'h64);
        agc_out <= -16'sh012C;
        repeat (3) @(posedge clk);
        #1;
        chk("agc_self_error", 18'sd200, agc_error);
        chk("step_slow", 18'h1, agc_step_mult);
        chk("adapt_off", 18'h0, agc_adapt_en);
        wr(ADDR_GAIN_CFG, 8'h03);
        #1;
        chk("step_fast", 18'h8, agc_step_mult);
        chk("adapt_on", 18'h1, agc_adapt_en);
        wr(ADDR_LVL_HI, 8'h01);
        for (int i = 0; i < 7; i++) begin
            sym(smp[i], 2'h1);
            mag = (eq_error < 0) ? -eq_error : eq_error;
            chk("slice_fb", sx[i], fb_sym);
            chk("slice_cu", sx[i], cu_sym);
            chk("eq_error", em[i], mag);
            if (i < 4) chk("slicer_error", 18'h0, slicer_error);
        end
        wr(ADDR_GAIN_CFG, 8'h04);
        repeat (2) @(posedge clk);
        #1;
        mag = (agc_error < 0) ? -agc_error : agc_error;
        chk("agc_eq_error", 18'h0FF, mag);
        wr(ADDR_LVL_LO, 8'hFF);
        wr(ADDR_LVL_HI, 8'h7F);
        sym(smp[7], 2'h1);
        chk("level_clamp", sx[7], fb_sym);
        wr(ADDR_DET_CFG, 8'h20);
        sym(16'sh0300, 2'h1);
        chk("mux_loop", 18'h1, cu_sym);
        chk("fb_slicer", 18'h3, fb_sym);
        wr(ADDR_DET_CFG, 8'h08);
        sym(16'sh0150, 2'h0);
        chk("two_level_pos", 18'h2, fb_sym);
        sym(-16'sh0150, 2'h0);
        chk("two_level_neg", 18'h0, fb_sym);
        wr(ADDR_DET_CFG, 8'h80);
        peak_hit <= 1'b1;
        peak_sym <= 2'h1;
        sym(16'sh0300, 2'h0);
        chk("peak_on", 18'h1, fb_sym);
        chk("eq_err_peak", 18'(16'sh0300 + LEVEL_MAX), eq_error);
        chk("slc_err_peak", 18'(16'sh0300 - LEVEL_MAX), slicer_error);
        wr(ADDR_DET_CFG, 8'h00);
        sym(16'sh0300, 2'h0);
        chk("peak_off", 18'h3, fb_sym);
        wr(ADDR_PK_DLY, 8'h04);
        peak_hit <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            dfe_sample <= 16'(i * 16);
            sym_valid <= 1'b1;
            @(negedge clk);
            if (i >= 4) chk("peak_delay", 18'((i - 4) * 16), 18'(peak_sample));
        end
        @(posedge clk);
        sym_valid <= 1'b0;
        wr(ADDR_DET_CFG, 8'h20);
        u_sink.got.delete();
        stall <= 1'b1;
        repeat (2) @(posedge clk);
        sym(16'sh0, 2'h1);
        sym(16'sh0, 2'h2);
        @(negedge clk);
        chk("buffer_full", 18'h0, sym_ready);
        chk("buffer_head", 18'h1, cu_sym);
        @(posedge clk);
        stall <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk("drained", 18'h2, 18'(u_sink.got.size()));
        chk("drain_order", 18'h6, {u_sink.got[0], u_sink.got[1]});
        // Reference scrambler; m[2] selects four-level, two bits per symbol
        for (int m = 0; m < 6; m++) begin
            do_reset();
            wr(ADDR_DET_CFG, (m[2] ? 8'h50 : 8'h58) | 8'(m[1:0]));
            wr(ADDR_LVL_HI, 8'h01);
            ls = '0;
            for (int i = 0; i < 40; i++) begin
                b = i[0] ^ i[2] ^ i[3];
                g = i[1] ^ i[4];
                o = (m[0] ? b : 1'b1) ^ ls[22] ^ (m[1] ? ls[4] : ls[17]);
                ls = {ls[21:0], m[0] ? b : o};
                o2 = (m[0] ? g : 1'b1) ^ ls[22] ^ (m[1] ? ls[4] : ls[17]);
                if (m[2]) ls = {ls[21:0], m[0] ? g : o2};
                else o2 = 1'b0;
                sym(b ? (g ? 16'sh0100 : 16'sh0300) : (g ? -16'sh0100 : -16'sh0300), 2'h0);
                chk("scr_cu", {o, o2}, cu_sym);
                chk("scr_fb", {o, o2}, fb_sym);
            end
        end
        // Limit 127 needs all 128 sign bits to agree
        do_reset();
        wr(ADDR_ALIGN_LIMIT, 8'h7F);
        wr(ADDR_DET_CFG, 8'h0C);
        for (k = 0; k < 151; k++) sym(-16'sh0500, 2'h0);
        chk("no_sync_on_miss", 18'h0, sync_flag);
        ls = '0;
        for (k = 0; k < 151; k++) begin
            if (k == 150) chk("no_sync_early", 18'h0, sync_flag);
            o = 1'b1 ^ ls[22] ^ ls[17];
            ls = {ls[21:0], o};
            sym(o ? 16'sh0500 : -16'sh0500, 2'h0);
        end
        chk("sync_found", 18'h1, sync_flag);
        pulse_clr(1'b0);
        chk("sync_held", 18'h1, sync_flag);
        rd(ADDR_DET_CFG, rv);
        chk("cfg_kept", 18'h0C, rv);
        wr(ADDR_DET_CFG, 8'h08);
        pulse_clr(1'b0);
        chk("sync_cleared", 18'h0, sync_flag);
        tally_and_finish();
    end
endmodule : sdsc_detector_bench
